// *** hw/fifo_mailbox_read_parity_generator.sv ***
// FIFO with two mailboxes and read-side lane parity generation
// What this block does
// - Parity-generate select makes parity on reads
// - Four 9-bit lanes, top bit is parity
// - Writes store all 36 bits unchanged
// - Parity from low eight bits, odd/even select
// - Generated bits replace lane top bits
// - FIFO parity made before output register
// - Port-B selects sampled at FIFO load edge
// - Mailbox parity reuses port check trees
// - Mailbox generation only on selected mailbox read
// - Mailbox contents untouched by parity generation
// - Close write edge delays empty release
// - Close read edge delays full release
// - Parity error forced inactive on generating mailbox read
// - Port-B outputs: FIFO register or mailbox
`timescale 1ns/1ps
module fifo_mailbox_read_parity_generator (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Port clock edges, one-cycle enables
  input wire logic write_port_clock,
  input wire logic read_port_clock,
  // Common parity sense, high selects odd
  input wire logic odd_even_sel,
  // Port A
  input wire logic porta_chip_select_n,
  input wire logic porta_enable,
  input wire logic porta_write_not_read,
  input wire logic porta_mailbox_sel,
  input wire logic porta_parity_gen_sel,
  input wire logic [35:0] portaDataIn,
  output logic [35:0] portaDataOut,
  output logic portaDataOe,
  output logic porta_parity_error_n,
  // Port B
  input wire logic portb_chip_select_n,
  input wire logic portb_enable,
  input wire logic portb_write_not_read,
  input wire logic portb_mailbox_sel,
  input wire logic portb_parity_gen_sel,
  input wire logic [35:0] portbDataIn,
  output logic [35:0] portbDataOut,
  output logic portbDataOe,
  output logic portb_parity_error_n,
  // FIFO and mailbox flags
  output logic empty_flag_n,
  output logic full_flag_n,
  output logic mailAToBEmptyN,
  output logic mailBToAEmptyN,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [31:0] regRdData,
  // Interrupt
  output logic irq
);

  localparam int W = fifo_parity_pkg::WORD_W;
  localparam int LW = fifo_parity_pkg::LANE_W;

  // Storage and pointers
  logic [W-1:0] memArray_ff [fifo_parity_pkg::DEPTH];
  logic [6:0] wrPtr_ff;
  logic [6:0] rdPtr_ff;
  logic [6:0] wrPtrRdSync1_ff;
  logic [6:0] wrPtrRdSync2_ff;
  logic [6:0] rdPtrWrSync1_ff;
  logic [6:0] rdPtrWrSync2_ff;
  logic [W-1:0] fifoOut_ff;

  // Mailboxes and interrupt state
  logic [W-1:0] mailbox_a_to_b;
  logic [W-1:0] mailbox_b_to_a;
  logic [3:0] status_ff;
  logic [3:0] mask_ff;
  logic [3:0] nxt_status;

  // Port request decode
  logic portaActive;
  logic portbActive;

  // Qualified strobes, each one core cycle wide
  logic fifoWrite;
  logic fifoRead;
  logic mailAWrite;
  logic mailBWrite;
  logic mailARead;
  logic mailBRead;

  // Mailbox generation requests, level sensitive
  logic mailGenA;
  logic mailGenB;

  // Parity trees and generated words
  logic [W-1:0] fifoRdWord;
  logic [W-1:0] fifoGenWord;
  logic [W-1:0] treeSrcA;
  logic [W-1:0] treeSrcB;
  logic [3:0] treeA;
  logic [3:0] treeB;
  logic [3:0] errLaneA;
  logic [3:0] errLaneB;
  logic [W-1:0] mailGenWordA;
  logic [W-1:0] mailGenWordB;

  assign portaActive = !porta_chip_select_n && porta_enable;
  assign portbActive = !portb_chip_select_n && portb_enable;

  // Port A strobes; refused writes leave no trace
  assign fifoWrite = write_port_clock && portaActive && porta_write_not_read
                     && !porta_mailbox_sel && full_flag_n;
  assign mailAWrite = write_port_clock && portaActive && porta_write_not_read
                      && porta_mailbox_sel && mailAToBEmptyN;
  assign mailARead = write_port_clock && portaActive && !porta_write_not_read
                     && porta_mailbox_sel;

  // Port B strobes
  assign fifoRead = read_port_clock && portbActive && !portb_write_not_read
                    && !portb_mailbox_sel && empty_flag_n;
  assign mailBWrite = read_port_clock && portbActive && portb_write_not_read
                      && portb_mailbox_sel && mailBToAEmptyN;
  assign mailBRead = read_port_clock && portbActive && !portb_write_not_read
                     && portb_mailbox_sel;

  // Generation needs no port edge: mailbox reads are plain levels
  assign mailGenA = portaActive && !porta_write_not_read
                    && porta_mailbox_sel && porta_parity_gen_sel;
  assign mailGenB = portbActive && !portb_write_not_read
                    && portb_mailbox_sel && portb_parity_gen_sel;

  // One tree per lane per port; the same tree checks the pins or builds mailbox parity
  assign treeSrcA = mailGenA ? mailbox_b_to_a : portaDataIn;
  assign treeSrcB = mailGenB ? mailbox_a_to_b : portbDataIn;
  // Array word at the read pointer, ahead of the output register
  assign fifoRdWord = memArray_ff[rdPtr_ff[5:0]];

  genvar l;
  generate
    for (l = 0; l < fifo_parity_pkg::LANES; l++) begin : gLane
      logic fifoPar;
      assign treeA[l] = ^treeSrcA[l*LW +: LW-1] ^ odd_even_sel;
      assign treeB[l] = ^treeSrcB[l*LW +: LW-1] ^ odd_even_sel;

      // Pin check: tree result against the received top bit
      assign errLaneA[l] = treeA[l] ^ portaDataIn[l*LW+LW-1];
      assign errLaneB[l] = treeB[l] ^ portbDataIn[l*LW+LW-1];

      // FIFO word gets its parity before the load
      assign fifoPar = ^fifoRdWord[l*LW +: LW-1] ^ odd_even_sel;
      // Low eight bits pass, top bit replaced
      assign fifoGenWord[l*LW +: LW] = {portb_parity_gen_sel ? fifoPar : fifoRdWord[l*LW+LW-1],
                                        fifoRdWord[l*LW +: LW-1]};
      assign mailGenWordA[l*LW +: LW] = {mailGenA ? treeA[l] : mailbox_b_to_a[l*LW+LW-1],
                                         mailbox_b_to_a[l*LW +: LW-1]};
      assign mailGenWordB[l*LW +: LW] = {mailGenB ? treeB[l] : mailbox_a_to_b[l*LW+LW-1],
                                         mailbox_a_to_b[l*LW +: LW-1]};
    end
  endgenerate

  // Pins checked in every direction, except on a generating mailbox read, which owns the tree
  assign porta_parity_error_n = mailGenA || !(|errLaneA);
  assign portb_parity_error_n = mailGenB || !(|errLaneB);

  // FIFO array, written as-is
  // No reset: contents are unknown until written
  always_ff @(posedge core_clk) begin
    if (fifoWrite) begin
      memArray_ff[wrPtr_ff[5:0]] <= portaDataIn;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      // Seventh bit tells full from empty
      wrPtr_ff <= fifo_parity_pkg::PTR_RESET;
    end else if (fifoWrite) begin
      wrPtr_ff <= wrPtr_ff + 7'h01;
    end
  end

  // Selects taken at the load edge, so the register holds final parity
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdPtr_ff <= fifo_parity_pkg::PTR_RESET;
      fifoOut_ff <= fifo_parity_pkg::WORD_RESET;
    end else if (fifoRead) begin
      rdPtr_ff <= rdPtr_ff + 7'h01;
      fifoOut_ff <= fifoGenWord;
    end
  end

  // Two-stage flag sync on each port's edge; a write in the same cycle as a read edge
  // is missed by the first stage, which costs one more read edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wrPtrRdSync1_ff <= fifo_parity_pkg::PTR_RESET;
      wrPtrRdSync2_ff <= fifo_parity_pkg::PTR_RESET;
    end else if (read_port_clock) begin
      wrPtrRdSync1_ff <= wrPtr_ff;
      wrPtrRdSync2_ff <= wrPtrRdSync1_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      // Mirror of the empty side on the write edge
      rdPtrWrSync1_ff <= fifo_parity_pkg::PTR_RESET;
      rdPtrWrSync2_ff <= fifo_parity_pkg::PTR_RESET;
    end else if (write_port_clock) begin
      rdPtrWrSync1_ff <= rdPtr_ff;
      rdPtrWrSync2_ff <= rdPtrWrSync1_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      empty_flag_n <= 1'b0;
    end else if (read_port_clock) begin
      // Compare against the pointer as it stands after this edge's read
      empty_flag_n <= (wrPtrRdSync2_ff != (fifoRead ? rdPtr_ff + 7'h01
                                                    : rdPtr_ff));
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      full_flag_n <= 1'b0;
    end else if (write_port_clock) begin
      // Full when the pointers differ only in the wrap bit
      full_flag_n <= ((fifoWrite ? wrPtr_ff + 7'h01 : wrPtr_ff)
                      != {~rdPtrWrSync2_ff[6], rdPtrWrSync2_ff[5:0]});
    end
  end

  // Mailboxes change only on writes, never on generating reads
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mailbox_a_to_b <= fifo_parity_pkg::WORD_RESET;
    end else if (mailAWrite) begin
      mailbox_a_to_b <= portaDataIn;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mailbox_b_to_a <= fifo_parity_pkg::WORD_RESET;
    end else if (mailBWrite) begin
      mailbox_b_to_a <= portbDataIn;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mailAToBEmptyN <= 1'b1;
    end else if (mailAWrite) begin
      // A write in the same cycle as a release wins
      mailAToBEmptyN <= 1'b0;
    end else if (mailBRead) begin
      mailAToBEmptyN <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mailBToAEmptyN <= 1'b1;
    end else if (mailBWrite) begin
      // A write in the same cycle as a release wins
      mailBToAEmptyN <= 1'b0;
    end else if (mailARead) begin
      mailBToAEmptyN <= 1'b1;
    end
  end

  // Output buses
  // Output enables follow the read select, no clock needed
  assign portaDataOe = portaActive && !porta_write_not_read;
  assign portbDataOe = portbActive && !portb_write_not_read;
  // Port A only ever shows the B-to-A mailbox
  assign portaDataOut = mailGenWordA;
  assign portbDataOut = portb_mailbox_sel ? mailGenWordB : fifoOut_ff;

  // Sticky events; a new event beats a same-cycle clear
  always_comb begin
    nxt_status = status_ff;
    if (regWrEn && regAddr == fifo_parity_pkg::REG_STATUS) begin
      nxt_status = status_ff & ~regWrData[3:0];
    end
    // Error bits only count on a port edge
    if (write_port_clock && portaActive && !porta_parity_error_n) begin
      nxt_status[fifo_parity_pkg::IRQ_PERR_A] = 1'b1;
    end
    if (read_port_clock && portbActive && !portb_parity_error_n) begin
      nxt_status[fifo_parity_pkg::IRQ_PERR_B] = 1'b1;
    end
    if (mailAWrite) begin
      nxt_status[fifo_parity_pkg::IRQ_MAIL_A2B] = 1'b1;
    end
    if (mailBWrite) begin
      nxt_status[fifo_parity_pkg::IRQ_MAIL_B2A] = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      // Clear-by-one write only touches bits 3:0
      status_ff <= 4'h0;
    end else begin
      status_ff <= nxt_status;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mask_ff <= fifo_parity_pkg::MASK_RESET;
    end else if (regWrEn && regAddr == fifo_parity_pkg::REG_MASK) begin
      mask_ff <= regWrData[3:0];
    end
  end

  // Level output; drops as soon as the status bit is cleared
  assign irq = |(status_ff & mask_ff);

  // Read data valid only the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      regRdData <= 32'h00000000;
    end else if (regRdEn) begin
      unique case (regAddr)
        fifo_parity_pkg::REG_STATUS: regRdData <= {28'h0000000, status_ff};
        fifo_parity_pkg::REG_MASK: regRdData <= {28'h0000000, mask_ff};
        fifo_parity_pkg::REG_FLAGS: regRdData <= {28'h0000000, mailBToAEmptyN, mailAToBEmptyN,
                                                  full_flag_n, empty_flag_n};
        // Unmapped offsets read as zero
        default: regRdData <= 32'h00000000;
      endcase
    end else begin
      // Zero outside the answer cycle
      regRdData <= 32'h00000000;
    end
  end

endmodule : fifo_mailbox_read_parity_generator

// *** hw/fifo_parity_pkg.sv ***
// Package: widths, register offsets, reset values for the read-parity FIFO block
package fifo_parity_pkg;
  localparam int WORD_W = 36;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int DEPTH = 64;
  localparam int PTR_W = 7;
  localparam int ADDR_W = 4;
  localparam int IRQ_W = 4;
  // Register offsets
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK = 4'h4;
  localparam logic [3:0] REG_FLAGS = 4'h8;
  // Status and mask bit positions
  localparam int IRQ_PERR_A = 0;
  localparam int IRQ_PERR_B = 1;
  localparam int IRQ_MAIL_A2B = 2;
  localparam int IRQ_MAIL_B2A = 3;
  // Reset values
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [35:0] WORD_RESET = 36'h000000000;
  localparam logic [6:0] PTR_RESET = 7'h00;
endpackage : fifo_parity_pkg

// *** bench/fifo_parity_checker.sv ***
// Checker: parity, flag and output relations at the block ports
`timescale 1ns/1ps
module fifo_parity_checker (
  // Watched ports
  input wire logic core_clk, rst, read_port_clock, write_port_clock, odd_even_sel,
  input wire logic porta_chip_select_n, porta_enable, porta_write_not_read, porta_mailbox_sel,
  input wire logic porta_parity_gen_sel, porta_parity_error_n, portb_parity_error_n,
  input wire logic portb_chip_select_n, portb_enable, portb_write_not_read, portb_mailbox_sel,
  input wire logic portb_parity_gen_sel, empty_flag_n, full_flag_n, portaDataOe, portbDataOe,
  input wire logic [35:0] portaDataOut, portbDataOut
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  function automatic logic lanesOk(logic [35:0] w, logic odd);
    return (^w[8:0] == odd) && (^w[17:9] == odd) && (^w[26:18] == odd) && (^w[35:27] == odd);
  endfunction : lanesOk
  logic rdA, rdB, genA, genB, fifoRd;
  assign rdA = !porta_chip_select_n && porta_enable && !porta_write_not_read;
  assign rdB = !portb_chip_select_n && portb_enable && !portb_write_not_read;
  assign genA = rdA && porta_mailbox_sel && porta_parity_gen_sel;
  assign genB = rdB && portb_mailbox_sel && portb_parity_gen_sel;
  assign fifoRd = rdB && read_port_clock && !portb_mailbox_sel && portb_parity_gen_sel && empty_flag_n;
  perr_hold_a_a: assert property (genA |-> porta_parity_error_n) else $error("port A error flag low");
  perr_hold_b_a: assert property (genB |-> portb_parity_error_n) else $error("port B error flag low");
  mbox_par_a_a: assert property (genA |-> lanesOk(portaDataOut, odd_even_sel)) else $error("A parity");
  mbox_par_b_a: assert property (genB |-> lanesOk(portbDataOut, odd_even_sel)) else $error("B parity");
  fifo_par_a: assert property (fifoRd ##1 !portb_mailbox_sel |-> lanesOk(portbDataOut, $past(odd_even_sel)))
    else $error("FIFO parity");
  fifo_hold_a: assert property (rdB && !portb_mailbox_sel && $stable(portb_mailbox_sel) && !$past(read_port_clock)
    && !$past(rst) |-> $stable(portbDataOut)) else $error("FIFO output moved");
  empty_rise_a: assert property ($rose(empty_flag_n) |-> $past(read_port_clock)) else $error("empty off-edge");
  full_rise_a: assert property ($rose(full_flag_n) |-> $past(write_port_clock)) else $error("full off-edge");
  oe_read_a: assert property (portaDataOe == rdA && portbDataOe == rdB) else $error("output enable");
  cover property (genA);
  cover property (genB);
  cover property (fifoRd);
endmodule : fifo_parity_checker

// *** bench/portb_host_model.sv ***
// Port-B host model: FIFO or mailbox reads, mailbox writes, chosen lag
`timescale 1ns/1ps
module portb_host_model (
  // Command from the bench
  input wire logic core_clk, bReq, bWr, bMb, bGen,
  input wire logic [2:0] bLag,
  input wire logic [35:0] bData,
  output logic bAck = 1'b0,
  // Port-B pins
  output logic read_port_clock = 1'b0,
  output logic portb_chip_select_n = 1'b1,
  output logic portb_enable = 1'b0,
  output logic portb_write_not_read = 1'b0,
  output logic portb_mailbox_sel = 1'b0,
  output logic portb_parity_gen_sel = 1'b0,
  output logic [35:0] portbDataIn = 36'h0
);
  logic busy = 1'b0;
  logic [2:0] cnt = 3'h0;
  always @(posedge core_clk) begin
    read_port_clock <= 1'b0;
    bAck <= 1'b0;
    if (bReq && !busy) begin
      // Selects held from request to release, across the port edge
      busy <= 1'b1;
      cnt <= bLag;
      portb_chip_select_n <= 1'b0;
      portb_enable <= 1'b1;
      portb_write_not_read <= bWr;
      portb_mailbox_sel <= bMb;
      portb_parity_gen_sel <= bGen;
      if (bWr) portbDataIn <= bData;
    end else if (busy) begin
      cnt <= cnt - 3'h1;
      if (cnt == 3'h0) read_port_clock <= 1'b1;
      if (cnt == 3'h7) bAck <= !portb_write_not_read;
      if (cnt == 3'h6) begin
        busy <= 1'b0;
        portb_chip_select_n <= 1'b1;
        portb_enable <= 1'b0;
        // Released bus shows the inverse, never a stale copy
        portbDataIn <= ~portbDataIn;
      end
    end
  end
endmodule : portb_host_model

// *** bench/tb_fifo_mailbox_read_parity_generator.sv ***
// Testbench: FIFO and mailbox parity generation, flags, registers, interrupt
`timescale 1ns/1ps
module tb_fifo_mailbox_read_parity_generator;
  logic core_clk = 1'b0, rst = 1'b1, write_port_clock = 1'b0, odd_even_sel = 1'b0, look = 1'b0;
  logic porta_chip_select_n = 1'b1, porta_enable = 1'b0, porta_write_not_read = 1'b0;
  logic porta_mailbox_sel = 1'b0, porta_parity_gen_sel = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
  logic bReq = 1'b0, bWr = 1'b0, bMb = 1'b0, bGen = 1'b0, bAck, irq;
  logic [2:0] bLag = 3'h0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0, regRdData;
  logic [35:0] portaDataIn = 36'h0, bData = 36'h0, w [4], portaDataOut, portbDataOut, portbDataIn, v, d2;
  logic read_port_clock, portb_chip_select_n, portb_enable, portb_write_not_read, portb_mailbox_sel;
  logic portb_parity_gen_sel, portaDataOe, portbDataOe, porta_parity_error_n, portb_parity_error_n;
  logic empty_flag_n, full_flag_n, mailAToBEmptyN, mailBToAEmptyN;
  logic [37:0] expQ [$];
  logic [37:0] e;
  logic [63:0] r64;
  string nm [4] = '{"portbDataOut", "portaDataOut", "regRdData", "irq"};
  int fail_count = 0, n_tests = 0;
  fifo_mailbox_read_parity_generator i_dut (.*);
  portb_host_model i_host (.*);
  always #20 core_clk = ~core_clk;
  // Results appear on host ack or bench look; oldest note is the expectation
  always @(negedge core_clk) begin
    if ((bAck || look) && expQ.size() > 0) begin
      e = expQ.pop_front();
      v = e[37:36] == 2'h0 ? portbDataOut : e[37:36] == 2'h1 ? portaDataOut :
        e[37:36] == 2'h2 ? {4'h0, regRdData} : {35'h0, irq};
      n_tests++;
      if (v !== e[35:0]) begin
        fail_count++;
        $display("ERROR %s expected %h seen %h", nm[e[37:36]], e[35:0], v);
      end
    end
  end
  function automatic logic [35:0] genp(logic [35:0] d, logic odd, logic gen);
    logic [35:0] r;
    r = d;
    for (int i = 0; i < 4; i++)
      if (gen) r[9 * i + 8] = (^d[9 * i +: 8]) ^ odd;
    return r;
  endfunction : genp
  task automatic breq(logic wr, mb, gen, odd, logic [2:0] lag, logic [35:0] d, ex);
    @(posedge core_clk);
    {bReq, bWr, bMb, bGen, odd_even_sel} <= {1'b1, wr, mb, gen, odd};
    bLag <= lag;
    bData <= d;
    if (!wr) expQ.push_back({2'h0, ex});
    @(posedge core_clk);
    bReq <= 1'b0;
    repeat (lag + 3) @(posedge core_clk);
  endtask : breq
  task automatic aop(logic wr, mb, gen, odd, logic [35:0] d, ex);
    @(posedge core_clk);
    {porta_chip_select_n, porta_enable, porta_write_not_read} <= {1'b0, 1'b1, wr};
    {porta_mailbox_sel, porta_parity_gen_sel, odd_even_sel, write_port_clock} <= {mb, gen, odd, 1'b1};
    portaDataIn <= d;
    look <= !wr;
    if (!wr) expQ.push_back({2'h1, ex});
    @(posedge core_clk);
    {write_port_clock, look, porta_chip_select_n, porta_enable} <= 4'h2;
    portaDataIn <= ~d;
  endtask : aop
  task automatic chk(logic [1:0] src, logic [35:0] ex);
    @(posedge core_clk);
    look <= 1'b1;
    expQ.push_back({src, ex});
    @(posedge core_clk);
    look <= 1'b0;
  endtask : chk
  task automatic reg_op(logic wr, logic [3:0] a, logic [31:0] d, logic [35:0] ex);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    {regWrEn, regRdEn} <= {wr, !wr};
    @(posedge core_clk);
    {regWrEn, regRdEn} <= 2'h0;
    if (!wr) begin
      look <= 1'b1;
      expQ.push_back({2'h2, ex});
      @(posedge core_clk);
      look <= 1'b0;
    end
  endtask : reg_op
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  initial begin
    #(40 * 3000);
    fail_count++;
    stop_test();
  end
  initial begin
    void'($urandom(32'hbb8c));
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    reg_op(1'b0, 4'h8, 32'h0, 36'hc);
    breq(1'b0, 1'b0, 1'b1, 1'b1, 3'h0, 36'h0, 36'h0);
    aop(1'b0, 1'b1, 1'b0, 1'b0, 36'h0, 36'h0);
    for (int i = 0; i < 4; i++) begin
      r64 = {$urandom, $urandom};
      w[i] = r64[35:0];
      aop(1'b1, 1'b0, 1'b0, 1'b0, w[i], 36'h0);
    end
    breq(1'b0, 1'b1, 1'b1, 1'b1, 3'h1, 36'h0, 36'h804020100);
    breq(1'b0, 1'b1, 1'b1, 1'b0, 3'h0, 36'h0, 36'h0);
    breq(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 36'h0, 36'h0);
    reg_op(1'b0, 4'h8, 32'h0, 36'hf);
    for (int i = 0; i < 4; i++)
      breq(1'b0, 1'b0, i[0], i[1], i[2:0], 36'h0, genp(w[i], i[1], i[0]));
    r64 = {$urandom, $urandom};
    d2 = r64[35:0];
    aop(1'b1, 1'b1, 1'b1, 1'b0, d2, 36'h0);
    breq(1'b0, 1'b1, 1'b1, 1'b0, 3'h2, 36'h0, genp(d2, 1'b0, 1'b1));
    breq(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 36'h0, d2);
    breq(1'b1, 1'b1, 1'b0, 1'b0, 3'h0, ~d2, 36'h0);
    aop(1'b0, 1'b1, 1'b1, 1'b1, 36'h0, genp(~d2, 1'b1, 1'b1));
    aop(1'b0, 1'b1, 1'b0, 1'b1, 36'h0, ~d2);
    reg_op(1'b1, 4'h0, 32'hf, 36'h0);
    reg_op(1'b0, 4'h0, 32'h0, 36'h0);
    reg_op(1'b1, 4'h4, 32'h4, 36'h0);
    aop(1'b1, 1'b1, 1'b0, 1'b0, 36'h0, 36'h0);
    reg_op(1'b0, 4'h0, 32'h0, 36'h4);
    chk(2'h3, 36'h1);
    reg_op(1'b1, 4'h4, 32'h0, 36'h0);
    chk(2'h3, 36'h0);
    reg_op(1'b1, 4'h4, 32'h4, 36'h0);
    chk(2'h3, 36'h1);
    reg_op(1'b1, 4'h0, 32'h4, 36'h0);
    chk(2'h3, 36'h0);
    reg_op(1'b1, 4'hc, 32'hf, 36'h0);
    reg_op(1'b0, 4'hc, 32'h0, 36'h0);
    reg_op(1'b0, 4'h4, 32'h0, 36'h4);
    stop_test();
  end
endmodule : tb_fifo_mailbox_read_parity_generator
bind fifo_mailbox_read_parity_generator fifo_parity_checker i_chk (.*);
